// ### dpot_ctrl.sv
// Purpose: Register bank and two-wire slave of a 128-tap digital potentiometer
// Assumes: Serial clock pin is the link clock; data pin edges clock the start/stop toggles; the rest runs on ref_clk
// Notes: Non-volatile array is modelled by a flop that reset does not touch
`include "dpot_regs.svh"
`default_nettype none
module dpot_ctrl #(
   parameter int NV_WRITE_CYC = `DPOT_NV_WRITE_CYC,
   parameter int RECALL_CYC = `DPOT_RECALL_CYC
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic scl_clk,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_select_pin,
   output logic [127:0] tap_close,
   output var dpot_pkg::dpot_pot_s pot
);
   // ---------------- Link domain (serial clock) ----------------
   dpot_pkg::dpot_link_e lk_state;
   logic [2:0] lk_bit;
   logic [7:0] lk_shift;
   logic lk_rw;
   logic lk_start_seen;
   dpot_pkg::dpot_link_e lk_after;
   logic [1:0] lk_pin_sync;
   logic [7:0] lk_reg_addr;
   logic lk_wr_tgl;
   dpot_pkg::dpot_wr_s lk_wr;
   logic lk_pull;
   logic [7:0] lk_tx;
   // Select pin comes from outside; two flops before the address compare
   always_ff @(posedge scl_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk_pin_sync <= 2'h0;
      end else begin
         lk_pin_sync <= {lk_pin_sync[0], addr_select_pin};
      end
   end
   // Start/stop are SDA edges while SCL is high; detected as async toggles
   logic start_tgl, stop_tgl;
   always_ff @(negedge sda_in or posedge sys_rst) begin
      if (sys_rst) begin
         start_tgl <= 1'b0;
      end else if (scl_clk) begin
         start_tgl <= ~start_tgl;
      end
   end
   always_ff @(posedge sda_in or posedge sys_rst) begin
      if (sys_rst) begin
         stop_tgl <= 1'b0;
      end else if (scl_clk) begin
         stop_tgl <= ~stop_tgl;
      end
   end
   wire [7:0] lk_byte = {lk_shift[6:0], sda_in};
   wire lk_new_start = (start_tgl != lk_start_seen);
   // Address match on the first byte
   wire lk_addr_hit = (lk_byte[7:3] == `DPOT_SLAVE_PREFIX) &&
      (lk_byte[2] == lk_pin_sync[1]) && (lk_byte[1] == 1'b0);
   // Sample on rising serial clock
   always_ff @(posedge scl_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk_state <= dpot_pkg::LK_IDLE;
         lk_bit <= 3'h0;
         lk_shift <= 8'h00;
         lk_rw <= 1'b0;
         lk_start_seen <= 1'b0;
         lk_reg_addr <= 8'h00;
         lk_wr_tgl <= 1'b0;
         lk_wr <= '0;
         lk_after <= dpot_pkg::LK_IDLE;
      end else begin
         lk_start_seen <= start_tgl;
         if (lk_new_start) begin
            lk_state <= dpot_pkg::LK_DEV;
            lk_bit <= 3'h1;
            lk_shift <= {7'h00, sda_in};
         end else begin
            unique case (lk_state)
               dpot_pkg::LK_IDLE: begin
                  lk_bit <= 3'h0;
               end
               dpot_pkg::LK_DEV, dpot_pkg::LK_REG, dpot_pkg::LK_WDATA: begin
                  lk_shift <= lk_byte;
                  lk_bit <= lk_bit + 3'h1;
                  if (lk_bit == 3'h7) begin
                     if (lk_state == dpot_pkg::LK_DEV) begin
                        lk_rw <= sda_in;
                        lk_after <= sda_in ? dpot_pkg::LK_RDATA : dpot_pkg::LK_REG;
                        lk_state <= lk_addr_hit ? dpot_pkg::LK_AACK : dpot_pkg::LK_IDLE;
                     end else if (lk_state == dpot_pkg::LK_REG) begin
                        lk_reg_addr <= lk_byte;
                        lk_after <= dpot_pkg::LK_WDATA;
                        lk_state <= dpot_pkg::LK_AACK;
                     end else begin
                        lk_wr.addr <= lk_reg_addr;
                        lk_wr.data <= lk_byte;
                        lk_wr_tgl <= ~lk_wr_tgl;
                        lk_state <= dpot_pkg::LK_AACK;
                     end
                  end
               end
               dpot_pkg::LK_AACK: begin
                  lk_bit <= 3'h0;
                  lk_state <= lk_after;
               end
               dpot_pkg::LK_RDATA: begin
                  lk_bit <= lk_bit + 3'h1;
                  if (lk_bit == 3'h7) begin
                     lk_state <= dpot_pkg::LK_MACK;
                  end
               end
               dpot_pkg::LK_MACK: begin
                  lk_bit <= 3'h0;
                  if (!sda_in) begin
                     lk_reg_addr <= lk_reg_addr + 8'h01;
                  end
                  lk_state <= sda_in ? dpot_pkg::LK_IDLE : dpot_pkg::LK_RDATA;
               end
               default: lk_state <= dpot_pkg::LK_IDLE;
            endcase
         end
      end
   end
   // Read data registered in ref_clk domain, handed over as a stable word
   logic [7:0] rd_word;
   logic [7:0] rd_word_lk1, rd_word_lk2;
   // Drive SDA after the falling serial clock edge
   always_ff @(negedge scl_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk_pull <= 1'b0;
         lk_tx <= 8'h00;
         rd_word_lk1 <= 8'h00;
         rd_word_lk2 <= 8'h00;
      end else begin
         rd_word_lk1 <= rd_word;
         rd_word_lk2 <= rd_word_lk1;
         unique case (lk_state)
            dpot_pkg::LK_AACK: begin
               lk_pull <= 1'b1;
               lk_tx <= lk_rw ? rd_word_lk2 : 8'h00;
            end
            dpot_pkg::LK_RDATA: begin
               lk_pull <= ~lk_tx[3'h7 - lk_bit];
            end
            default: begin
               lk_pull <= 1'b0;
            end
         endcase
      end
   end
   // Open-drain: only pull low or release
   assign sda_out = 1'b0;
   assign sda_oe = lk_pull;
   // ---------------- System domain ----------------
   logic [2:0] wr_sync, stop_sync;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_sync <= 3'h0;
         stop_sync <= 3'h0;
      end else if (clk_en) begin
         wr_sync <= {wr_sync[1:0], lk_wr_tgl};
         stop_sync <= {stop_sync[1:0], stop_tgl};
      end
   end
   wire wr_evt = wr_sync[2] ^ wr_sync[1];
   wire stop_evt = stop_sync[2] ^ stop_sync[1];
   // Write word is stable once its toggle has crossed
   wire [7:0] w_addr = lk_wr.addr;
   wire [7:0] w_data = lk_wr.data;
   logic [6:0] wiper;
   // Non-volatile storage: no reset, power-on content is the shipping value
   logic [6:0] ivr_nv = `DPOT_IVR_SHIP;
   logic mode_div = 1'b0;
   logic prec_off = 1'b0;
   logic vol_sel, power_down_n, nv_write_busy;
   logic [31:0] nv_cnt;
   logic [15:0] recall_cnt;
   logic recall_done;
   logic nv_pend;
   logic [6:0] nv_val;
   wire hit_wiper = wr_evt && (w_addr == `DPOT_ADDR_WIPER);
   wire hit_mode = wr_evt && (w_addr == `DPOT_ADDR_MODE);
   wire hit_acr = wr_evt && (w_addr == `DPOT_ADDR_ACCESS);
   wire wr_open = !nv_write_busy && recall_done;
   wire wr_wiper = hit_wiper && wr_open;
   wire wr_ivr = wr_wiper && !vol_sel;
   wire wr_mode = hit_mode && wr_open;
   wire wr_acr = hit_acr && wr_open;
   always_ff @(posedge ref_clk) begin
      if (clk_en && nv_cnt == 32'h1 && nv_pend) begin
         ivr_nv <= nv_val;
      end
      if (clk_en && wr_mode) begin
         mode_div <= w_data[`DPOT_MSR_MODE_BIT];
         prec_off <= w_data[`DPOT_MSR_PREC_BIT];
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wiper <= `DPOT_WIPER_MID;
         recall_cnt <= 16'h0000;
         recall_done <= 1'b0;
         vol_sel <= 1'b0;
         power_down_n <= 1'b1;
         nv_write_busy <= 1'b0;
         nv_cnt <= 32'h0;
         nv_pend <= 1'b0;
         nv_val <= 7'h00;
      end else if (clk_en) begin
         if (!recall_done) begin
            recall_cnt <= recall_cnt + 16'h0001;
            if (recall_cnt == 16'(RECALL_CYC)) begin
               recall_done <= 1'b1;
               wiper <= ivr_nv;
            end
         end else if (wr_wiper) begin
            wiper <= w_data[6:0];
         end
         if (wr_acr) begin
            vol_sel <= w_data[`DPOT_ACR_VOL_BIT];
            power_down_n <= w_data[`DPOT_ACR_PDN_BIT];
         end
         if (wr_ivr || wr_mode) begin
            nv_pend <= 1'b1;
            nv_val <= wr_ivr ? w_data[6:0] : ivr_nv;
         end
         if (stop_evt && nv_pend && !nv_write_busy) begin
            nv_write_busy <= 1'b1;
            nv_cnt <= 32'(NV_WRITE_CYC);
         end else if (nv_write_busy) begin
            nv_cnt <= nv_cnt - 32'h1;
            if (nv_cnt == 32'h1) begin
               nv_write_busy <= 1'b0;
               nv_pend <= 1'b0;
            end
         end
      end
   end
   // Read mux
   wire [7:0] acr_rd = {vol_sel, power_down_n, nv_write_busy, 5'h00};
   wire [7:0] msr_rd = {mode_div, prec_off, 6'h00};
   wire [7:0] wip_rd = {1'b0, vol_sel ? wiper : ivr_nv};
   wire [7:0] next_rd = (lk_reg_addr == `DPOT_ADDR_MODE) ? msr_rd :
      (lk_reg_addr == `DPOT_ADDR_ACCESS) ? acr_rd :
      (lk_reg_addr == `DPOT_ADDR_WIPER) ? wip_rd : 8'h00;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_word <= 8'h00;
      end else if (clk_en) begin
         rd_word <= next_rd;
      end
   end
   // Make before break: new tap closes one cycle before the old opens
   logic [6:0] tap_old;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tap_old <= `DPOT_WIPER_MID;
      end else if (clk_en) begin
         tap_old <= wiper;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < 128; gi++) begin : g_tap
         assign tap_close[gi] = (wiper == 7'(gi)) || (tap_old == 7'(gi));
      end
   endgenerate
   assign pot = '{wiper: wiper, mode_div: mode_div, prec_off: prec_off,
      power_down_n: power_down_n};
endmodule
`default_nettype wire

// ### dpot_regs.svh
// Purpose: Register offsets, fields, reset values and timing of the pot register block
// Assumes: 40 MHz ref_clk
// Notes: Shared by the package users and the design
`ifndef DPOT_REGS_SVH
`define DPOT_REGS_SVH
`define DPOT_ADDR_WIPER 8'h00
`define DPOT_ADDR_MODE 8'h01
`define DPOT_ADDR_ACCESS 8'h02
`define DPOT_ACR_VOL_BIT 7
`define DPOT_ACR_PDN_BIT 6
`define DPOT_ACR_BUSY_BIT 5
`define DPOT_MSR_MODE_BIT 7
`define DPOT_MSR_PREC_BIT 6
`define DPOT_WIPER_MID 7'h40
`define DPOT_IVR_SHIP 7'h40
`define DPOT_SLAVE_PREFIX 5'h0A
`define DPOT_CLK_HZ 40000000
`define DPOT_NV_WRITE_MS 20
`define DPOT_NV_WRITE_CYC ((`DPOT_CLK_HZ / 1000) * `DPOT_NV_WRITE_MS)
`define DPOT_RECALL_NS 1000
`define DPOT_RECALL_CYC ((`DPOT_RECALL_NS * (`DPOT_CLK_HZ / 1000000) + 999) / 1000)
`endif

// ### dpot_pkg.sv
// Purpose: Types of the pot register block
// Assumes: Nothing beyond the register header
// Notes: Link writes cross into ref_clk as one struct; the stop event crosses as its own toggle
`default_nettype none
package dpot_pkg;
   typedef enum logic [6:0] {
      LK_IDLE = 7'b0000001,
      LK_DEV = 7'b0000010,
      LK_AACK = 7'b0000100,
      LK_REG = 7'b0001000,
      LK_WDATA = 7'b0010000,
      LK_RDATA = 7'b0100000,
      LK_MACK = 7'b1000000
   } dpot_link_e;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } dpot_wr_s;
   typedef struct packed {
      logic [6:0] wiper;
      logic mode_div;
      logic prec_off;
      logic power_down_n;
   } dpot_pot_s;
endpackage
`default_nettype wire

// ### dpot_ctrl_sva.sv
// Purpose: Port-level checks of the pot register block
// Assumes: Bound into every dpot_ctrl instance
// Notes: Serial pins are sampled on ref_clk
`default_nettype none
module dpot_ctrl_sva #(
   parameter int NV_WRITE_CYC = 100,
   parameter int RECALL_CYC = 40
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic scl_clk,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic addr_select_pin,
   input wire logic [127:0] tap_close,
   input wire dpot_pkg::dpot_pot_s pot
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   int rcnt;
   // Cycles since reset release, saturating at the recall time
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rcnt <= 0;
      end else if (clk_en && rcnt < RECALL_CYC) begin
         rcnt <= rcnt + 1;
      end
   end
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   oe_after_fall_a: assert property ($changed(sda_oe) |-> !scl_clk)
      else $error("data drive moved while clock high");
   oe_steady_high_a: assert property (scl_clk && $past(scl_clk) |-> $stable(sda_oe))
      else $error("data drive unstable in clock high");
   tap_count_a: assert property ($countones(tap_close) inside {1, 2})
      else $error("wrong number of closed taps");
   break_after_a: assert property ($countones(tap_close) == 2 |=> $countones(tap_close) == 1)
      else $error("old tap not opened");
   tap_match_a: assert property ($stable(pot.wiper) [*3] |-> tap_close == (128'h1 << pot.wiper))
      else $error("closed tap differs from wiper");
   reset_state_a: assert property (disable iff (1'b0)
      sys_rst |-> pot.wiper == 7'h40 && pot.power_down_n && !sda_oe)
      else $error("bad state in reset");
   recall_hold_a: assert property (rcnt < RECALL_CYC - 2 |-> pot.wiper == 7'h40)
      else $error("wiper left mid-scale before recall");
   idle_release_a: assert property (scl_clk [*4] |-> !sda_oe)
      else $error("data pulled low on idle bus");
endmodule
bind dpot_ctrl dpot_ctrl_sva #(.NV_WRITE_CYC(NV_WRITE_CYC), .RECALL_CYC(RECALL_CYC))
   u_dpot_ctrl_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .addr_select_pin(addr_select_pin), .tap_close(tap_close), .pot(pot));
`default_nettype wire

// ### dpot_master.sv
// Purpose: Two-wire bus master driving serial clock and data
// Assumes: 80 ns clock period, pull-up on the data wire
// Notes: Clock stands high between frames
`default_nettype none
module dpot_master (
   output logic scl,
   output logic sda_m,
   input wire logic sda_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial scl = 1'b1;
   initial sda_m = 1'b1;
   // Start or repeated start: data falls while clock is high
   task automatic start();
      sda_m = 1'b1;
      #20 scl = 1'b1;
      #40 sda_m = 1'b0;
      #40 scl = 1'b0;
   endtask
   task automatic stop();
      #10 sda_m = 1'b0;
      #30 scl = 1'b1;
      #40 sda_m = 1'b1;
      #40;
   endtask
   task automatic bit_io(input logic b, output logic r);
      #10 sda_m = b;
      #30 scl = 1'b1;
      #20 r = sda_in;
      #20 scl = 1'b0;
   endtask
   // MSB first; the ninth bit carries the acknowledge
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
         output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack);
   endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: Self-checking bench of the pot register block
// Assumes: Bus master model drives the serial pins
// Notes: Short non-volatile cycle keeps the run brief
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic sys_rst;
   logic clk_en = 1'b1;
   logic addr_select_pin = 1'b0;
   logic scl_clk, sda_m, sda_in, sda_out, sda_oe;
   logic [127:0] tap_close;
   dpot_pkg::dpot_pot_s pot;
   int bad_count = 0;
   int checked = 0;
   assign sda_in = sda_m & ~sda_oe;
   always #12.5 ref_clk = ~ref_clk;
   dpot_ctrl #(.NV_WRITE_CYC(400), .RECALL_CYC(40)) u_dpot_ctrl (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .clk_en(clk_en), .scl_clk(scl_clk), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(addr_select_pin),
      .tap_close(tap_close), .pot(pot));
   dpot_master u_dpot_master (.scl(scl_clk), .sda_m(sda_m), .sda_in(sda_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One register access; a read ends with a refused acknowledge
   task automatic acc(input logic rnw, input logic [7:0] ra, input logic [7:0] wd,
         output logic [7:0] q);
      logic [7:0] id;
      logic [2:0] a;
      logic nk;
      id = {5'h0A, addr_select_pin, 2'b00};
      u_dpot_master.start();
      u_dpot_master.xfer(id, 1'b1, q, a[2]);
      u_dpot_master.xfer(ra, 1'b1, q, a[1]);
      if (rnw) begin
         u_dpot_master.start();
         u_dpot_master.xfer(id | 8'h01, 1'b1, q, a[0]);
         u_dpot_master.xfer(8'hFF, 1'b1, q, nk);
      end else begin
         u_dpot_master.xfer(wd, 1'b1, id, a[0]);
      end
      u_dpot_master.stop();
      chk({5'h00, a}, 8'h00, "acknowledges");
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic put(input logic [7:0] ra, input logic [7:0] wd);
      logic [7:0] q;
      acc(1'b0, ra, wd, q);
   endtask
   task automatic wait_idle();
      logic [7:0] d;
      for (int i = 0; i < 20; i++) begin
         acc(1'b1, 8'h02, 8'h00, d);
         if (d[5] === 1'b0) return;
      end
      bad_count++;
      $display("MISMATCH %0t busy never cleared", $time);
      end_sim();
   endtask
   task automatic t_reset();
      logic [7:0] d;
      chk({1'b0, pot.wiper}, 8'h40, "recalled wiper");
      chk({5'h00, pot.mode_div, pot.prec_off, pot.power_down_n}, 8'h01, "defaults");
      acc(1'b1, 8'h02, 8'h00, d);
      chk(d, 8'h40, "access defaults");
      acc(1'b1, 8'h03, 8'h00, d);
      chk(d, 8'h00, "unmapped read");
      $display("reset test done");
   endtask
   task automatic t_nv();
      logic [7:0] d;
      put(8'h00, 8'h55);
      chk({1'b0, pot.wiper}, 8'h55, "wiper follows");
      put(8'h02, 8'hC0);
      acc(1'b1, 8'h02, 8'h00, d);
      chk(d, 8'h60, "busy, write refused");
      wait_idle();
      acc(1'b1, 8'h00, 8'h00, d);
      chk(d, 8'h55, "stored value");
      $display("nv write test done");
   endtask
   task automatic t_vol();
      logic [7:0] d;
      logic [7:0] v[2] = '{8'h7F, 8'h00};
      put(8'h02, 8'hC0);
      foreach (v[i]) begin
         put(8'h00, v[i]);
         chk({1'b0, pot.wiper}, v[i], "volatile wiper");
         acc(1'b1, 8'h00, 8'h00, d);
         chk(d, v[i], "wiper readback");
      end
      acc(1'b1, 8'h02, 8'h00, d);
      chk(d, 8'hC0, "no busy");
      put(8'h02, 8'h80);
      chk({7'h00, pot.power_down_n}, 8'h00, "shutdown");
      put(8'h02, 8'hC0);
      chk({7'h00, pot.power_down_n}, 8'h01, "wake");
      $display("volatile test done");
   endtask
   task automatic t_mode();
      logic [7:0] d;
      put(8'h01, 8'hFF);
      chk({6'h00, pot.mode_div, pot.prec_off}, 8'h03, "mode set");
      wait_idle();
      acc(1'b1, 8'h01, 8'h00, d);
      chk({6'h00, d[7:6]}, 8'h03, "mode readback");
      put(8'h01, 8'h3F);
      chk({6'h00, pot.mode_div, pot.prec_off}, 8'h00, "mode clear");
      wait_idle();
      $display("mode test done");
   endtask
   task automatic t_addr();
      logic [7:0] q;
      logic a;
      @(posedge ref_clk);
      #2 addr_select_pin = 1'b1;
      put(8'h00, 8'h22);
      u_dpot_master.start();
      u_dpot_master.xfer(8'hA0, 1'b1, q, a);
      chk({7'h00, a}, 8'h01, "foreign address");
      u_dpot_master.xfer(8'h00, 1'b1, q, a);
      u_dpot_master.xfer(8'h33, 1'b1, q, a);
      u_dpot_master.stop();
      chk({1'b0, pot.wiper}, 8'h22, "ignored frame");
      @(posedge ref_clk);
      #2 addr_select_pin = 1'b0;
      $display("address test done");
   endtask
   task automatic t_recall();
      @(posedge ref_clk);
      #2 sys_rst = 1'b1;
      repeat (8) @(posedge ref_clk);
      #2 sys_rst = 1'b0;
      @(posedge ref_clk);
      chk({1'b0, pot.wiper}, 8'h40, "mid-scale");
      repeat (50) @(posedge ref_clk);
      chk({1'b0, pot.wiper}, 8'h55, "recall");
      $display("recall test done");
   endtask
   initial begin
      #2ms;
      bad_count++;
      $display("MISMATCH %0t run timed out", $time);
      end_sim();
   end
   initial begin
      sys_rst = 1'b1;
      repeat (8) @(posedge ref_clk);
      #2 sys_rst = 1'b0;
      repeat (50) @(posedge ref_clk);
      t_reset();
      t_nv();
      t_vol();
      t_mode();
      t_addr();
      t_recall();
      end_sim();
   end
endmodule
`default_nettype wire
